// *** hdl/cmwg_ctrl.sv ***
`timescale 1ns/1ps
module cmwg_ctrl #(
    parameter int unsigned WAKE_CYCLES = cmwg_pkg::CMWG_WAKE_CYCLES
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic hv_wake_pin_a,
    input wire logic hv_wake_pin_b,
    input wire logic sleep_cmd,
    input wire logic discharge_ctrl_a,
    input wire logic discharge_ctrl_b,
    input wire logic charge_ctrl,
    input wire logic overtemp_enable,
    input wire logic overtemp_mask,
    input wire logic overtemp_lockout_enable,
    input wire logic junction_over_threshold,
    input wire logic junction_below_release,
    input wire logic balance_wr,
    input wire logic [7:0] balance_wr_data,
    input wire logic flag_reg_read,
    output logic wake_status_a,
    output logic wake_status_b,
    output logic sleep_state,
    output logic regulator_output,
    output logic discharge_gate_a,
    output logic discharge_gate_b,
    output logic charge_gate,
    output logic [7:0] balance_switch_ctrl,
    output logic balance_locked,
    output logic overtemp_status,
    output logic overtemp_flag
);

    typedef struct packed {
        cmwg_pkg::cmwg_mode_t mode;
        logic wk_a;
        logic wk_b;
        logic reg_on;
        logic dg_a;
        logic dg_b;
        logic cg;
        logic [cmwg_pkg::CMWG_BAL_W-1:0] bal;
        logic lock;
        logic ot_st;
        logic ot_flg;
    } cmwg_state_t;

    logic rst_meta;
    logic rst_n;
    logic qual_a;
    logic qual_b;
    logic bal_active;
    logic lock_trip;
    logic awake_next;
    cmwg_state_t st;
    cmwg_state_t next_st;

    // Asynchronous assert, synchronous release of the reset.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    cmwg_wake_qual #(.CYCLES(WAKE_CYCLES)) u_qual_a (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_above(hv_wake_pin_a),
        .wake_event(qual_a)
    );

    cmwg_wake_qual #(.CYCLES(WAKE_CYCLES)) u_qual_b (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_above(hv_wake_pin_b),
        .wake_event(qual_b)
    );

    always_comb begin
        next_st = st;
        bal_active = overtemp_enable && (st.bal != cmwg_pkg::CMWG_BAL_RESET);
        lock_trip = bal_active && overtemp_lockout_enable && junction_over_threshold;

        // Wake status mirrors the comparator level in every mode.
        next_st.wk_a = hv_wake_pin_a;
        next_st.wk_b = hv_wake_pin_b;

        unique case (st.mode)
            cmwg_pkg::CMWG_AWAKE: begin
                if (sleep_cmd && !st.wk_a && !st.wk_b) begin
                    next_st.mode = cmwg_pkg::CMWG_SLEEP;
                end
            end
            cmwg_pkg::CMWG_SLEEP: begin
                if (qual_a || qual_b) begin
                    next_st.mode = cmwg_pkg::CMWG_AWAKE;
                end
            end
        endcase
        awake_next = (next_st.mode == cmwg_pkg::CMWG_AWAKE);
        next_st.reg_on = awake_next;

        next_st.dg_a = discharge_ctrl_a && awake_next;
        next_st.dg_b = discharge_ctrl_b && awake_next;
        next_st.cg = charge_ctrl;

        if (balance_wr) begin
            if (balance_wr_data == cmwg_pkg::CMWG_BAL_RELEASE) begin
                next_st.bal = cmwg_pkg::CMWG_BAL_RESET;
                next_st.lock = 1'b0;
            end else if (!st.lock) begin
                next_st.bal = balance_wr_data;
            end
        end
        // Entering or staying in sleep turns every balance switch off.
        if (!awake_next) begin
            next_st.bal = cmwg_pkg::CMWG_BAL_RESET;
        end

        if (!bal_active) begin
            next_st.ot_st = 1'b0;
        end else if (junction_over_threshold) begin
            next_st.ot_st = 1'b1;
        end else if (junction_below_release) begin
            next_st.ot_st = 1'b0;
        end

        // A trip in the same cycle as a release write wins, so it is not lost.
        if (lock_trip) begin
            next_st.bal = cmwg_pkg::CMWG_BAL_RESET;
            next_st.lock = 1'b1;
        end

        if (flag_reg_read) begin
            next_st.ot_flg = 1'b0;
        end
        if (next_st.ot_st && !st.ot_st && !overtemp_mask) begin
            next_st.ot_flg = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st.mode <= cmwg_pkg::CMWG_MODE_RESET;
            st.wk_a <= cmwg_pkg::CMWG_BIT_RESET;
            st.wk_b <= cmwg_pkg::CMWG_BIT_RESET;
            st.reg_on <= 1'b1;
            st.dg_a <= cmwg_pkg::CMWG_BIT_RESET;
            st.dg_b <= cmwg_pkg::CMWG_BIT_RESET;
            st.cg <= cmwg_pkg::CMWG_BIT_RESET;
            st.bal <= cmwg_pkg::CMWG_BAL_RESET;
            st.lock <= cmwg_pkg::CMWG_BIT_RESET;
            st.ot_st <= cmwg_pkg::CMWG_BIT_RESET;
            st.ot_flg <= cmwg_pkg::CMWG_BIT_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign wake_status_a = st.wk_a;
    assign wake_status_b = st.wk_b;
    assign sleep_state = (st.mode == cmwg_pkg::CMWG_SLEEP);
    assign regulator_output = st.reg_on;
    assign discharge_gate_a = st.dg_a;
    assign discharge_gate_b = st.dg_b;
    assign charge_gate = st.cg;
    assign balance_switch_ctrl = st.bal;
    assign balance_locked = st.lock;
    assign overtemp_status = st.ot_st;
    assign overtemp_flag = st.ot_flg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_wake_follow: assert property (clk_en |=> wake_status_a == $past(hv_wake_pin_a)
        && wake_status_b == $past(hv_wake_pin_b))
        else $error("wake status does not follow wake pins");
    a_wake_exit: assert property (clk_en && sleep_state && (qual_a || qual_b)
        |=> !sleep_state && regulator_output)
        else $error("no wake after qualified pulse");
    a_stay_asleep: assert property (clk_en && sleep_state && !qual_a && !qual_b
        |=> sleep_state && !regulator_output)
        else $error("left sleep without qualified pulse");
    a_dgate_a_follow: assert property (clk_en |=> discharge_gate_a
        == ($past(discharge_ctrl_a) && !sleep_state))
        else $error("discharge gate A wrong");
    a_dgate_b_follow: assert property (clk_en |=> discharge_gate_b
        == ($past(discharge_ctrl_b) && !sleep_state))
        else $error("discharge gate B wrong");
    a_dgate_sleep_low: assert property (sleep_state |-> !discharge_gate_a && !discharge_gate_b)
        else $error("discharge gate high in sleep");
    a_cgate_follow: assert property (clk_en |=> charge_gate == $past(charge_ctrl))
        else $error("charge gate does not follow control");
    a_sleep_refused: assert property (clk_en && !sleep_state
        && (wake_status_a || wake_status_b) |=> !sleep_state)
        else $error("sleep taken while wake status high");
    a_ot_inactive: assert property (clk_en && (!overtemp_enable
        || balance_switch_ctrl == 8'h00) |=> !overtemp_status)
        else $error("overtemp status while detection inactive");
    a_ot_hold: assert property (clk_en && overtemp_status && bal_active
        && !junction_below_release |=> overtemp_status)
        else $error("overtemp status cleared inside hysteresis");
    a_ot_flag_set: assert property ($rose(overtemp_status) && $past(clk_en)
        && !$past(overtemp_mask) |-> overtemp_flag)
        else $error("overtemp flag not set on rising status");
    a_ot_flag_mask: assert property (clk_en && !overtemp_flag && (overtemp_mask
        || !bal_active) |=> !overtemp_flag)
        else $error("overtemp flag set while masked or inactive");
    a_lock_blocks: assert property (clk_en && balance_locked |=> balance_switch_ctrl == 8'h00)
        else $error("balance switch on while locked");
    a_lock_release: assert property (clk_en && balance_wr && balance_wr_data == 8'h00
        && !lock_trip |=> !balance_locked)
        else $error("lock not released by zero write");

    c_sleep_entry: cover property (clk_en && !sleep_state ##1 sleep_state);
    c_wake_exit: cover property (sleep_state ##1 !sleep_state);
    c_lockout: cover property (clk_en && lock_trip ##1 balance_locked);
    c_flag_read: cover property (overtemp_flag ##1 clk_en && flag_reg_read ##1 !overtemp_flag);
    c_freeze: cover property (!clk_en && balance_wr ##1 !clk_en);

    // A low clock enable must freeze every bit of state, wake counting included.
    a_freeze_hold: assert property (
        !clk_en |=> $stable(st))
        else $error("state changed while clock enable low");

    // Mode, regulator and the sleep command.
    a_sleep_entry: assert property (
        clk_en && !sleep_state && sleep_cmd && !wake_status_a && !wake_status_b |=> sleep_state)
        else $error("sleep command with idle wake status not taken");
    a_sleep_no_cmd: assert property (
        clk_en && !sleep_state && !sleep_cmd |=> !sleep_state)
        else $error("sleep entered without a command");
    a_reg_mode: assert property (
        regulator_output != sleep_state)
        else $error("regulator output disagrees with mode");
    a_wake_sleep_low: assert property (
        clk_en && sleep_state && !hv_wake_pin_a && !hv_wake_pin_b
        |=> !wake_status_a && !wake_status_b)
        else $error("wake status high in sleep without high voltage");

    // Balance switches and their lock.
    a_sleep_bal_off: assert property (
        clk_en && sleep_state && !qual_a && !qual_b |=> balance_switch_ctrl == 8'h00)
        else $error("balance switch on in sleep");
    a_lock_trip: assert property (
        clk_en && lock_trip |=> balance_locked && balance_switch_ctrl == 8'h00)
        else $error("over-temperature trip did not lock balance switches");
    a_lock_hold: assert property (
        clk_en && balance_locked && !(balance_wr && balance_wr_data == 8'h00)
        |=> balance_locked)
        else $error("lock released without zero write");
    a_lock_needs_trip: assert property (
        clk_en && !balance_locked && !lock_trip |=> !balance_locked)
        else $error("lock set without a trip");
    a_bal_write: assert property (
        clk_en && balance_wr && !balance_locked && !lock_trip && !sleep_state && !sleep_cmd
        |=> balance_switch_ctrl == $past(balance_wr_data))
        else $error("balance write not applied");
    a_bal_keep: assert property (
        clk_en && !balance_wr && !lock_trip && !sleep_state && !sleep_cmd
        |=> balance_switch_ctrl == $past(balance_switch_ctrl))
        else $error("balance switches changed without a write");

    // Over-temperature status and flag.
    a_ot_set: assert property (
        clk_en && bal_active && junction_over_threshold |=> overtemp_status)
        else $error("overtemp status not set above threshold");
    a_ot_release: assert property (
        clk_en && junction_below_release && !junction_over_threshold |=> !overtemp_status)
        else $error("overtemp status held below release level");
    a_flag_clear: assert property (
        clk_en && flag_reg_read && (overtemp_status || overtemp_mask || !bal_active
        || !junction_over_threshold) |=> !overtemp_flag)
        else $error("overtemp flag not cleared by read");
    a_flag_hold: assert property (
        clk_en && overtemp_flag && !flag_reg_read |=> overtemp_flag)
        else $error("overtemp flag lost without read");
    a_flag_needs_rise: assert property (
        clk_en && !overtemp_flag && overtemp_status |=> !overtemp_flag)
        else $error("overtemp flag set without status rise");

    // Gate drivers keep off while their controls are low, and the charge gate turns on while its control is high.
    a_dgate_off: assert property (
        clk_en && !discharge_ctrl_a && !discharge_ctrl_b
        |=> !discharge_gate_a && !discharge_gate_b)
        else $error("discharge gate on with control low");
    a_cgate_off: assert property (
        clk_en && !charge_ctrl |=> !charge_gate)
        else $error("charge gate on with control low");
    a_cgate_on: assert property (
        clk_en && charge_ctrl |=> charge_gate)
        else $error("charge gate off with control high");

endmodule // cmwg_ctrl

// *** hdl/cmwg_wake_qual.sv ***
`timescale 1ns/1ps
module cmwg_wake_qual #(
    parameter int unsigned CYCLES = cmwg_pkg::CMWG_WAKE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic pin_above,
    output logic wake_event
);

    typedef struct packed {
        logic [cmwg_pkg::CMWG_WAKE_CNT_W-1:0] cnt;
        logic evt;
    } cmwg_qual_t;

    localparam logic [cmwg_pkg::CMWG_WAKE_CNT_W-1:0] LAST =
        cmwg_pkg::CMWG_WAKE_CNT_W'(CYCLES - 1);

    cmwg_qual_t st;
    cmwg_qual_t next_st;

    always_comb begin
        next_st = st;
        next_st.evt = 1'b0;
        if (!pin_above) begin
            next_st.cnt = '0;
        end else if (st.cnt < LAST) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (st.cnt == LAST) begin
            // The count parks one past the last so the event fires once per pulse.
            next_st.cnt = st.cnt + 1'b1;
            next_st.evt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign wake_event = st.evt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_qual_restart: assert property (clk_en && !pin_above |=> st.cnt == '0)
        else $error("wake count not restarted on pin drop");
    a_qual_fire: assert property (clk_en && pin_above && st.cnt == LAST |=> wake_event)
        else $error("wake event missing after full pulse");

endmodule // cmwg_wake_qual

// *** shared/cmwg_pkg.sv ***
package cmwg_pkg;

    typedef enum logic [0:0] {
        CMWG_AWAKE = 1'b0,
        CMWG_SLEEP = 1'b1
    } cmwg_mode_t;

    localparam int CMWG_CLK_MHZ = 250;
    localparam int CMWG_WAKE_MIN_MS = 1;
    // Least time, so it rounds up; 1 ms at 250 MHz is an exact count.
    localparam int CMWG_WAKE_CYCLES = CMWG_WAKE_MIN_MS * CMWG_CLK_MHZ * 1000;
    localparam int CMWG_WAKE_CNT_W = 18;

    localparam int CMWG_BAL_W = 8;
    localparam logic [7:0] CMWG_BAL_RELEASE = 8'h00;
    localparam logic [7:0] CMWG_BAL_RESET = 8'h00;
    localparam cmwg_mode_t CMWG_MODE_RESET = CMWG_AWAKE;
    localparam logic CMWG_BIT_RESET = 1'b0;

endpackage

// *** verif/cmwg_host_model.sv ***
`timescale 1ns/1ps
module cmwg_host_model (
    input wire logic core_clk,
    output logic sleep_cmd,
    output logic balance_wr,
    output logic [7:0] balance_wr_data,
    output logic flag_reg_read
);
    initial begin
        sleep_cmd = 1'b0;
        balance_wr = 1'b0;
        balance_wr_data = 8'hA5;
        flag_reg_read = 1'b0;
    end

    // Writes the whole balance byte in one strobe; released data is scrambled, not held.
    task automatic write_balance(input logic [7:0] data);
        @(negedge core_clk);
        balance_wr <= 1'b1;
        balance_wr_data <= data;
        @(negedge core_clk);
        balance_wr <= 1'b0;
        balance_wr_data <= ~data;
    endtask

    // A read of the flag register, which also clears the over-temperature flag.
    task automatic read_flags();
        @(negedge core_clk);
        flag_reg_read <= 1'b1;
        @(negedge core_clk);
        flag_reg_read <= 1'b0;
    endtask

    task automatic request_sleep();
        @(negedge core_clk);
        sleep_cmd <= 1'b1;
        @(negedge core_clk);
        sleep_cmd <= 1'b0;
    endtask
endmodule // cmwg_host_model

// *** verif/tb_cell_monitor_wake_gate_thermal_ctrl.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module tb_cell_monitor_wake_gate_thermal_ctrl;
    localparam int WAKE_N = 8;
    logic core_clk, resetn, pin_a, pin_b, ctrl_a, ctrl_b, chg_ctrl;
    logic ot_en, ot_mask, ot_lock, over, below;
    logic sleep_cmd, balance_wr, flag_reg_read;
    logic [7:0] balance_wr_data, balance_switch_ctrl;
    logic wake_status_a, wake_status_b, sleep_state, regulator_output;
    logic discharge_gate_a, discharge_gate_b, charge_gate, balance_locked;
    logic overtemp_status, overtemp_flag, clk_en;
    int num_errors = 0;
    int num_checks = 0;
    int seed = 11768;

    cmwg_host_model host (.core_clk(core_clk), .sleep_cmd(sleep_cmd), .balance_wr(balance_wr),
        .balance_wr_data(balance_wr_data), .flag_reg_read(flag_reg_read));
    cmwg_ctrl #(.WAKE_CYCLES(WAKE_N)) dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .hv_wake_pin_a(pin_a), .hv_wake_pin_b(pin_b), .sleep_cmd(sleep_cmd),
        .discharge_ctrl_a(ctrl_a), .discharge_ctrl_b(ctrl_b), .charge_ctrl(chg_ctrl),
        .overtemp_enable(ot_en), .overtemp_mask(ot_mask), .overtemp_lockout_enable(ot_lock),
        .junction_over_threshold(over), .junction_below_release(below),
        .balance_wr(balance_wr), .balance_wr_data(balance_wr_data),
        .flag_reg_read(flag_reg_read), .wake_status_a(wake_status_a),
        .wake_status_b(wake_status_b), .sleep_state(sleep_state),
        .regulator_output(regulator_output), .discharge_gate_a(discharge_gate_a),
        .discharge_gate_b(discharge_gate_b), .charge_gate(charge_gate),
        .balance_switch_ctrl(balance_switch_ctrl), .balance_locked(balance_locked),
        .overtemp_status(overtemp_status), .overtemp_flag(overtemp_flag));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end

    initial begin
        {resetn, pin_a, pin_b, ctrl_a, ctrl_b, chg_ctrl, ot_en, ot_mask, ot_lock, over, below} = '0;
        clk_en = 1'b1;
        step(3);
        resetn = 1'b1;
        step(3);
        `CHK({discharge_gate_a, discharge_gate_b, charge_gate}, 3'h0)
        `CHK({balance_switch_ctrl, balance_locked, regulator_output}, 10'h001)
        for (int i = 0; i < 40; i++) begin
            {pin_a, pin_b, ctrl_a, ctrl_b, chg_ctrl} = 5'($random(seed));
            step(1);
            `CHK({discharge_gate_a, discharge_gate_b}, {ctrl_a, ctrl_b})
            `CHK(charge_gate, chg_ctrl)
            `CHK({wake_status_a, wake_status_b}, {pin_a, pin_b})
        end
        {pin_a, pin_b, ctrl_a, ctrl_b, chg_ctrl} = 5'h1F;
        step(1);
        pin_a = 1'b0;
        pin_b = 1'b0;
        step(1);
        host.request_sleep();
        `CHK({sleep_state, regulator_output}, 2'h2)
        `CHK({discharge_gate_a, discharge_gate_b, wake_status_a, wake_status_b}, 4'h0)
        `CHK(charge_gate, 1'b1)
        pin_a = 1'b1;
        step(WAKE_N - 3);
        `CHK(wake_status_a, 1'b1)
        pin_a = 1'b0;
        step(2);
        `CHK(sleep_state, 1'b1)
        pin_b = 1'b1;
        step(WAKE_N - 2);
        `CHK(sleep_state, 1'b1)
        step(4);
        `CHK({sleep_state, regulator_output, discharge_gate_a}, 3'h3)
        host.request_sleep();
        `CHK(sleep_state, 1'b0)
        pin_b = 1'b0;
        ot_en = 1'b1;
        host.write_balance(8'h0F);
        `CHK(balance_switch_ctrl, 8'h0F)
        over = 1'b1;
        step(1);
        `CHK({overtemp_status, overtemp_flag}, 2'h3)
        over = 1'b0;
        step(2);
        `CHK(overtemp_status, 1'b1)
        below = 1'b1;
        step(1);
        `CHK(overtemp_status, 1'b0)
        host.read_flags();
        `CHK(overtemp_flag, 1'b0)
        ot_mask = 1'b1;
        over = 1'b1;
        below = 1'b0;
        step(1);
        `CHK({overtemp_status, overtemp_flag}, 2'h2)
        ot_en = 1'b0;
        step(1);
        `CHK(overtemp_status, 1'b0)
        ot_en = 1'b1;
        ot_lock = 1'b1;
        step(1);
        `CHK({balance_switch_ctrl, balance_locked}, 9'h001)
        over = 1'b0;
        host.write_balance(8'h55);
        `CHK({balance_switch_ctrl, balance_locked}, 9'h001)
        host.write_balance(8'h00);
        `CHK(balance_locked, 1'b0)
        over = 1'b1;
        step(2);
        `CHK(overtemp_status, 1'b0)
        over = 1'b0;
        host.write_balance(8'h3C);
        `CHK(balance_switch_ctrl, 8'h3C)
        clk_en = 1'b0;
        chg_ctrl = 1'b0;
        host.write_balance(8'h00);
        `CHK({charge_gate, balance_switch_ctrl}, 9'h13C)
        clk_en = 1'b1;
        step(1);
        `CHK(charge_gate, 1'b0)
        resetn = 1'b0;
        step(1);
        `CHK({balance_switch_ctrl, discharge_gate_a, charge_gate, regulator_output}, 11'h001)
        resetn = 1'b1;
        step(3);
        `CHK({balance_switch_ctrl, balance_locked}, 9'h000)
        give_verdict();
    end
endmodule // tb_cell_monitor_wake_gate_thermal_ctrl
